// ---- inc/fdccfg_pkg.sv ----
// shared constants and types of the configuration access unit
package fdccfg_pkg;

    // ----------------------------------------------------------------
    // host offsets and key values
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_INDEX = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_DOR = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h4;
    localparam logic [2:0] ADDR_FIFO = 3'h5;
    localparam logic [7:0] KEY_ENTER = 8'h55;
    localparam logic [7:0] KEY_EXIT = 8'haa;
    localparam logic [2:0] IDX_HIGH_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // register indices and bit positions
    // ----------------------------------------------------------------
    localparam logic [4:0] IDX_POWER = 5'h00;
    localparam logic [4:0] IDX_LOCK = 5'h01;
    localparam logic [4:0] IDX_DRVMODE = 5'h03;
    localparam logic [4:0] IDX_DENSDMA = 5'h05;
    localparam logic [4:0] IDX_DTYPE = 5'h06;
    localparam logic [4:0] IDX_APM = 5'h07;
    localparam logic [4:0] IDX_RATE = 5'h0b;
    localparam logic [4:0] IDX_PARTID = 5'h0d;
    localparam logic [4:0] IDX_PARTREV = 5'h0e;
    localparam logic [4:0] IDX_TEST_A = 5'h0f;
    localparam logic [4:0] IDX_TEST_B = 5'h10;
    localparam logic [4:0] IDX_TEST_C = 5'h11;
    localparam logic [4:0] IDX_DSEL = 5'h1f;
    localparam int PDEN_BIT = 2;
    localparam int PWR_BIT = 3;
    localparam int OSC_BIT = 5;
    localparam int LOCK_BIT = 7;
    localparam int APM_BIT = 7;
    localparam int DOR_RESET_N_BIT = 2;
    localparam int DOR_DMA_BIT = 3;
    localparam int DOR_MOTOR_LSB = 4;
    localparam int DSR_RESET_BIT = 7;
    localparam logic [7:0] DOR_RESET_VAL = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FDCCFG_NORMAL = 3'b001,
        FDCCFG_KEY1 = 3'b010,
        FDCCFG_CONFIG = 3'b100
    } fdccfg_mode_t;

    typedef struct packed {
        logic chip_select_n;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } fdccfg_bus_t;

    typedef struct packed {
        logic [1:0] drive_sel;
        logic write_serial;
        logic write_gate;
        logic seek_dir;
        logic step;
        logic head_side_select;
        logic density_select;
        logic [1:0] rate_code;
        logic irq;
        logic dma_request;
    } fdccfg_core_t;

    typedef struct packed {
        logic [3:0] motor_on_out;
        logic [3:0] drive_select_out;
        logic write_serial_out;
        logic write_gate_out;
        logic seek_dir_out;
        logic step_out;
        logic head_side_select;
        logic density_select;
        logic [1:0] rate_code_out;
        logic irq_out;
        logic dma_request_out;
        logic motor_on_oe;
        logic drive_select_oe;
        logic write_serial_oe;
        logic write_gate_oe;
    } fdccfg_drv_t;

    typedef struct packed {
        logic osc_on;
        logic pd_pin_en;
        logic [7:0] drive_mode_options;
        logic [7:0] density_dma_options;
        logic [7:0] drive_type_map;
        logic [7:0] autopower_boot_media;
        logic [7:0] drive_rate_table;
        logic [7:0] drive_type_select;
    } fdccfg_cfg_t;

    // ----------------------------------------------------------------
    // per-index defaults, writable bits and bits that read as one
    // ----------------------------------------------------------------
    function automatic logic [7:0] cfg_default(input logic [4:0] idx);
        case (idx)
            IDX_POWER: cfg_default = 8'h28;
            IDX_LOCK: cfg_default = 8'h90;
            IDX_DRVMODE: cfg_default = 8'h70;
            IDX_DTYPE: cfg_default = 8'hff;
            default: cfg_default = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] cfg_wmask(input logic [4:0] idx);
        case (idx)
            IDX_POWER: cfg_wmask = 8'hac;
            IDX_DRVMODE: cfg_wmask = 8'h72;
            IDX_DENSDMA: cfg_wmask = 8'h7c;
            IDX_DTYPE, IDX_APM, IDX_RATE, IDX_TEST_A, IDX_TEST_B,
            IDX_TEST_C, IDX_DSEL: cfg_wmask = 8'hff;
            default: cfg_wmask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] cfg_fixed_ones(input logic [4:0] idx);
        case (idx)
            IDX_LOCK: cfg_fixed_ones = 8'h10;
            default: cfg_fixed_ones = 8'h00;
        endcase
    endfunction

endpackage

// ---- testbench/fdccfg_host_model.sv ----
// host processor model driving the byte-wide configuration bus
`timescale 1ns/1ps
module fdccfg_host_model
    import fdccfg_pkg::*;
(
    input wire logic clk,
    output fdccfg_bus_t host,
    input wire logic [7:0] host_rdata,
    input wire logic host_rdata_valid
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    // released data lines show the inverse of the last byte, not a copy
    initial host = '{chip_select_n: 1'b1, rd: 1'b0, wr: 1'b0,
                     addr: 3'h7, wdata: 8'h00};

    task automatic write_byte(input logic [2:0] a, input logic [7:0] d,
                              input logic cs_n);
        @(posedge clk);
        host.chip_select_n <= cs_n;
        host.wr <= 1'b1;
        host.addr <= a;
        host.wdata <= d;
        @(posedge clk);
        host.chip_select_n <= 1'b1;
        host.wr <= 1'b0;
        host.wdata <= ~d;
    endtask

    task automatic read_byte(input logic [2:0] a, output logic [7:0] d,
                             output logic v);
        @(posedge clk);
        host.chip_select_n <= 1'b0;
        host.rd <= 1'b1;
        host.addr <= a;
        @(posedge clk);
        host.chip_select_n <= 1'b1;
        host.rd <= 1'b0;
        #1;
        d = host_rdata;
        v = host_rdata_valid;
    endtask

    // ----------------------------------------------------------------
    // configuration sequences
    // ----------------------------------------------------------------
    // nothing else is issued between the keys, as if interrupts masked
    task automatic enter_config();
        write_byte(ADDR_INDEX, KEY_ENTER, 1'b0);
        write_byte(ADDR_INDEX, KEY_ENTER, 1'b0);
    endtask

    task automatic exit_config();
        write_byte(ADDR_INDEX, KEY_EXIT, 1'b0);
    endtask

    task automatic cfg_write(input logic [4:0] idx, input logic [7:0] d);
        write_byte(ADDR_INDEX, {IDX_HIGH_ZERO, idx}, 1'b0);
        write_byte(ADDR_DATA, d, 1'b0);
    endtask

    task automatic cfg_read(input logic [4:0] idx, output logic [7:0] d,
                            output logic v);
        write_byte(ADDR_INDEX, {IDX_HIGH_ZERO, idx}, 1'b0);
        read_byte(ADDR_DATA, d, v);
    endtask
endmodule

// ---- testbench/fdccfg_top_tb.sv ----
// self-checking bench of the configuration access unit
`timescale 1ns/1ps
module fdccfg_top_tb;
    import fdccfg_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
    localparam logic [7:0] REV_VAL = 8'h02; // arbitrary identity value
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic por_rst = 1'b1;
    logic clk_en = 1'b1;
    logic core_idle = 1'b0;
    fdccfg_core_t core = '0;
    fdccfg_bus_t host;
    fdccfg_drv_t drv;
    fdccfg_cfg_t cfg;
    logic [7:0] host_rdata;
    logic host_rdata_valid, core_powered, auto_powerdown, config_mode;
    int n_errors = 0;
    int samples_checked = 0;
    int wakes = 0;
    logic [7:0] rd_d;
    logic rd_v;
    logic [4:0] def_idx [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
        5'h06, 5'h07, 5'h0b, 5'h0d, 5'h0e, 5'h1f};
    logic [7:0] def_val [11] = '{8'h28, 8'h90, 8'h00, 8'h70, 8'h00,
        8'hff, 8'h00, 8'h00, ID_VAL, REV_VAL, 8'h00};
    logic [4:0] wr_idx [11] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06,
        5'h0b, 5'h0d, 5'h0f, 5'h10, 5'h11, 5'h1f};
    // reserved and read-only bits must survive an all-ones write
    logic [7:0] wr_val [11] = '{8'hac, 8'h00, 8'h72, 8'h7c, 8'hff,
        8'hff, ID_VAL, 8'hff, 8'hff, 8'hff, 8'hff};

    always #12.5 clk = ~clk;
    // power-up turns an unknown level low, which is not a wake
    always @(negedge auto_powerdown)
        if (!por_rst)
            wakes++;

    fdccfg_top #(.PART_ID(ID_VAL), .PART_REV(REV_VAL)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .clk_en(clk_en),
        .host(host), .host_rdata(host_rdata),
        .host_rdata_valid(host_rdata_valid), .core_idle(core_idle),
        .core(core), .drv(drv), .cfg(cfg), .core_powered(core_powered),
        .auto_powerdown(auto_powerdown), .config_mode(config_mode));

    fdccfg_host_model host_u (.clk(clk), .host(host),
        .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd_check(input string name, input logic [4:0] idx,
                            input logic [7:0] exp);
        host_u.cfg_read(idx, rd_d, rd_v);
        check(name, {7'h0, rd_v}, 8'h01);
        check(name, rd_d, exp);
    endtask

    task automatic hard_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        wait_cyc(1);
    endtask

    task automatic wait_pd(input logic exp);
        int k;
        k = 0;
        while (auto_powerdown !== exp && k < 20)
        begin
            wait_cyc(1);
            k++;
        end
        wait_cyc(2);
        check("auto_powerdown", {7'h0, auto_powerdown}, {7'h0, exp});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        wait_cyc(1);
        check("mode_at_start", {7'h0, config_mode}, 8'h00);
        host_u.read_byte(ADDR_DATA, rd_d, rd_v);
        check("data_outside_mode", {7'h0, rd_v}, 8'h00);
        host_u.write_byte(ADDR_INDEX, KEY_ENTER, 1'b1);
        host_u.write_byte(ADDR_INDEX, KEY_ENTER, 1'b1);
        wait_cyc(1);
        check("mode_unselected", {7'h0, config_mode}, 8'h00);
        host_u.write_byte(ADDR_INDEX, KEY_ENTER, 1'b0);
        host_u.write_byte(ADDR_DOR, 8'h04, 1'b0);
        host_u.write_byte(ADDR_INDEX, KEY_ENTER, 1'b0);
        wait_cyc(1);
        check("mode_cancelled", {7'h0, config_mode}, 8'h00);
        host_u.write_byte(ADDR_INDEX, KEY_ENTER, 1'b0);
        wait_cyc(1);
        check("mode_entered", {7'h0, config_mode}, 8'h01);
        for (int i = 0; i < 11; i++)
            rd_check("default", def_idx[i], def_val[i]);
        @(posedge clk);
        clk_en <= 1'b0;
        host_u.cfg_write(IDX_TEST_A, 8'h5a);
        clk_en <= 1'b1;
        rd_check("frozen_write", IDX_TEST_A, 8'h00);
        $display("test entry and defaults done");

        for (int i = 0; i < 11; i++)
        begin
            host_u.cfg_write(wr_idx[i], 8'hff);
            rd_check("readback", wr_idx[i], wr_val[i]);
        end
        check("cfg_dtype", cfg.drive_type_map, 8'hff);
        check("cfg_dmode", cfg.drive_mode_options, 8'h72);
        check("cfg_dens", cfg.density_dma_options, 8'h7c);
        check("cfg_bits", {6'h0, cfg.osc_on, cfg.pd_pin_en}, 8'h03);
        check("cfg_rate", cfg.drive_rate_table & cfg.drive_type_select,
            8'hff);
        host_u.cfg_write(IDX_POWER, 8'h20);
        wait_cyc(2);
        check("core_off", {7'h0, core_powered}, 8'h00);
        host_u.cfg_write(IDX_POWER, 8'h28);
        wait_cyc(2);
        check("core_on", {7'h0, core_powered}, 8'h01);
        host_u.write_byte(ADDR_INDEX, 8'h3f, 1'b0);
        host_u.read_byte(ADDR_DATA, rd_d, rd_v);
        check("bad_index_kept", rd_d, 8'h28);
        $display("test register access done");

        host_u.exit_config();
        wait_cyc(1);
        check("mode_exit", {7'h0, config_mode}, 8'h00);
        host_u.read_byte(ADDR_DATA, rd_d, rd_v);
        check("data_after_exit", {7'h0, rd_v}, 8'h00);
        hard_reset();
        check("mode_after_reset", {7'h0, config_mode}, 8'h00);
        host_u.enter_config();
        rd_check("kept_rate", IDX_RATE, 8'hff);
        rd_check("kept_test", IDX_TEST_C, 8'hff);
        $display("test exit and reset done");

        host_u.cfg_write(IDX_LOCK, 8'h00);
        host_u.cfg_read(IDX_DTYPE, rd_d, rd_v);
        check("locked_read", {7'h0, rd_v}, 8'h00);
        host_u.cfg_write(IDX_LOCK, 8'h80);
        host_u.cfg_read(IDX_LOCK, rd_d, rd_v);
        check("still_locked", {7'h0, rd_v}, 8'h00);
        hard_reset();
        host_u.enter_config();
        rd_check("lock_reopened", IDX_LOCK, 8'h90);
        $display("test lock done");

        // sleep with every core output high so floating pins show up
        host_u.cfg_write(IDX_APM, 8'h80);
        host_u.exit_config();
        check("cfg_apm", cfg.autopower_boot_media, 8'h80);
        core <= '1;
        core_idle <= 1'b1;
        host_u.write_byte(ADDR_DOR, 8'h04, 1'b0);
        wait_pd(1'b1);
        check("pd_float", {4'h0, drv.motor_on_oe, drv.drive_select_oe,
            drv.write_serial_oe, drv.write_gate_oe}, 8'h00);
        check("pd_active", {2'h0, drv.seek_dir_out, drv.step_out,
            drv.head_side_select, drv.density_select,
            drv.rate_code_out}, 8'h3f);
        check("pd_req", {6'h0, drv.irq_out, drv.dma_request_out}, 8'h00);
        host_u.write_byte(ADDR_DOR, 8'h0c, 1'b0);
        host_u.write_byte(ADDR_STAT, 8'h00, 1'b0);
        host_u.read_byte(ADDR_DOR, rd_d, rd_v);
        check("pd_host_read", {rd_d[6:0], rd_v}, 8'h19);
        wait_cyc(2);
        check("plain_writes", wakes[7:0], 8'h00);
        host_u.write_byte(ADDR_DOR, 8'h1c, 1'b0);
        wait_pd(1'b0);
        check("motor_out", {4'h0, drv.motor_on_out}, 8'h01);
        check("awake_oe", {4'h0, drv.motor_on_oe, drv.drive_select_oe,
            drv.write_serial_oe, drv.write_gate_oe}, 8'h0f);
        check("drive_sel", {4'h0, drv.drive_select_out}, 8'h08);
        check("awake_req", {6'h0, drv.irq_out, drv.dma_request_out},
            8'h03);
        host_u.write_byte(ADDR_DOR, 8'h0c, 1'b0);
        wait_pd(1'b1);
        host_u.write_byte(ADDR_STAT, 8'h80, 1'b0);
        wait_cyc(2);
        check("dsr_reset_wake", wakes[7:0], 8'h02);
        $display("test powerdown done");
        stop_test();
    end
endmodule

// ---- verilog/fdccfg_top.sv ----
// configuration access unit with auto powerdown pin control
//
// Operation
// - in powerdown, plain DRIVE_OUTPUT_REG/DSR writes keep sleep; motor or reset bit wakes
// - in powerdown, motor, select, write data and write gate pins float
// - in powerdown, direction, step, head, density and rate pins stay active
// - index port at +0, data port at +1, both need chip select
// - two back-to-back 55H writes to +0 enter configuration mode
// - any other write between the two keys cancels the entry
// - index 0 to 1FH at +0 routes data port accesses to that register
// - writing AAH to +0 leaves configuration mode
// - power-up loads all defaults and starts outside configuration mode
// - registers keep values over reset; only marked bits reset
// - index register is reachable only in configuration mode
// - cleared lock bit blocks all register access until hard reset
// - cleared core power bit puts the controller core in low power
`timescale 1ns/1ps
module fdccfg_top
    import fdccfg_pkg::*;
#(
    // arbitrary identity values
    parameter logic [7:0] PART_ID = 8'h5a,
    parameter logic [7:0] PART_REV = 8'h01
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic clk_en,
    input wire fdccfg_bus_t host,
    output logic [7:0] host_rdata,
    output logic host_rdata_valid,
    input wire logic core_idle,
    input wire fdccfg_core_t core,
    output fdccfg_drv_t drv,
    output fdccfg_cfg_t cfg,
    output logic core_powered,
    output logic auto_powerdown,
    output logic config_mode
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    fdccfg_mode_t mode;
    logic [4:0] cfg_index;
    logic [7:0] cfg_mem [0:31];
    logic [7:0] drive_output_reg;
    logic auto_pd;
    logic wr_any, rd_any;
    logic wr_index, wr_data, rd_data, wr_dor, wr_dsr;
    logic cfg_open, lock_open;
    logic wake;
    logic [7:0] sel_value;

    function automatic logic hit(input fdccfg_bus_t b, input logic [2:0] a);
        hit = !b.chip_select_n && b.addr == a;
    endfunction

    assign wr_any = host.wr && !host.chip_select_n;
    assign rd_any = host.rd && !host.chip_select_n;
    assign wr_index = host.wr && hit(host, ADDR_INDEX);
    assign wr_data = host.wr && hit(host, ADDR_DATA);
    assign rd_data = host.rd && hit(host, ADDR_DATA);
    assign wr_dor = host.wr && hit(host, ADDR_DOR);
    assign wr_dsr = host.wr && hit(host, ADDR_STAT);
    assign cfg_open = mode == FDCCFG_CONFIG;
    assign lock_open = cfg_mem[IDX_LOCK][LOCK_BIT];

    // ----------------------------------------------------------------
    // configuration mode sequencer
    // ----------------------------------------------------------------
    // a read between the keys is harmless; only writes cancel
    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
            mode <= FDCCFG_NORMAL;
        else if (clk_en && wr_any)
        begin
            case (mode)
                FDCCFG_NORMAL:
                    if (wr_index && host.wdata == KEY_ENTER)
                        mode <= FDCCFG_KEY1;
                FDCCFG_KEY1:
                    if (wr_index && host.wdata == KEY_ENTER)
                        mode <= FDCCFG_CONFIG;
                    else
                        mode <= FDCCFG_NORMAL;
                FDCCFG_CONFIG:
                    if (wr_index && host.wdata == KEY_EXIT)
                        mode <= FDCCFG_NORMAL;
                default:
                    mode <= FDCCFG_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (por_rst)
            cfg_index <= IDX_POWER;
        else if (clk_en && cfg_open && wr_index
                 && host.wdata[7:5] == IDX_HIGH_ZERO)
            cfg_index <= host.wdata[4:0];
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // only power-up restores defaults; hard reset re-opens the lock alone
    always_ff @(posedge clk)
    begin
        if (por_rst)
        begin
            for (int i = 0; i < 32; i++)
                cfg_mem[i] <= cfg_default(5'(i));
        end
        else if (sys_rst)
            cfg_mem[IDX_LOCK][LOCK_BIT] <= 1'b1;
        else if (clk_en && cfg_open && wr_data && lock_open)
        begin
            cfg_mem[cfg_index] <= (cfg_mem[cfg_index]
                & ~cfg_wmask(cfg_index))
                | (host.wdata & cfg_wmask(cfg_index));
            if (cfg_index == IDX_LOCK && !host.wdata[LOCK_BIT])
                cfg_mem[IDX_LOCK][LOCK_BIT] <= 1'b0;
        end
    end

    always_comb
    begin
        case (cfg_index)
            IDX_PARTID: sel_value = PART_ID;
            IDX_PARTREV: sel_value = PART_REV;
            default: sel_value = (cfg_mem[cfg_index]
                & (cfg_wmask(cfg_index) | cfg_default(cfg_index)))
                | cfg_fixed_ones(cfg_index);
        endcase
    end

    // ----------------------------------------------------------------
    // host read path
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
        begin
            host_rdata <= BYTE_ZERO;
            host_rdata_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            host_rdata_valid <= 1'b0;
            if (rd_data && cfg_open && lock_open)
            begin
                host_rdata <= sel_value;
                host_rdata_valid <= 1'b1;
            end
            else if (host.rd && hit(host, ADDR_DOR))
            begin
                host_rdata <= drive_output_reg;
                host_rdata_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // drive output register and auto powerdown
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
            drive_output_reg <= DOR_RESET_VAL;
        else if (clk_en && wr_dor)
            drive_output_reg <= host.wdata; // kept while asleep
    end

    // status read and fifo access wake as well; a plain dor write does not
    assign wake = (wr_dor && (host.wdata[7:DOR_MOTOR_LSB] != 4'h0
                   || !host.wdata[DOR_RESET_N_BIT]))
                  || (wr_dsr && host.wdata[DSR_RESET_BIT])
                  || (rd_any && host.addr == ADDR_STAT)
                  || ((wr_any || rd_any) && host.addr == ADDR_FIFO);

    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
            auto_pd <= 1'b0;
        else if (clk_en)
        begin
            if (!cfg_mem[IDX_APM][APM_BIT] || wake)
                auto_pd <= 1'b0;
            else if (core_idle && drive_output_reg[7:DOR_MOTOR_LSB] == 4'h0)
                auto_pd <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // pins and exported settings
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
            drv <= '0;
        else if (clk_en)
        begin
            drv.motor_on_out <= drive_output_reg[7:DOR_MOTOR_LSB];
            drv.drive_select_out <= 4'(4'h1 << core.drive_sel);
            drv.write_serial_out <= core.write_serial;
            drv.write_gate_out <= core.write_gate;
            drv.motor_on_oe <= !auto_pd;
            drv.drive_select_oe <= !auto_pd;
            drv.write_serial_oe <= !auto_pd;
            drv.write_gate_oe <= !auto_pd;
            drv.seek_dir_out <= core.seek_dir;
            drv.step_out <= core.step;
            drv.head_side_select <= core.head_side_select;
            drv.density_select <= core.density_select;
            drv.rate_code_out <= core.rate_code;
            drv.irq_out <= core.irq && !auto_pd;
            drv.dma_request_out <= core.dma_request && !auto_pd
                && drive_output_reg[DOR_DMA_BIT];
        end
    end

    // the core is also held low while asleep, not only by the power bit
    always_ff @(posedge clk)
    begin
        if (sys_rst || por_rst)
            core_powered <= 1'b1;
        else if (clk_en)
            core_powered <= cfg_mem[IDX_POWER][PWR_BIT] && !auto_pd;
    end

    always_comb
    begin
        cfg.osc_on = cfg_mem[IDX_POWER][OSC_BIT];
        cfg.pd_pin_en = cfg_mem[IDX_POWER][PDEN_BIT];
        cfg.drive_mode_options = cfg_mem[IDX_DRVMODE];
        cfg.density_dma_options = cfg_mem[IDX_DENSDMA];
        cfg.drive_type_map = cfg_mem[IDX_DTYPE];
        cfg.autopower_boot_media = cfg_mem[IDX_APM];
        cfg.drive_rate_table = cfg_mem[IDX_RATE];
        cfg.drive_type_select = cfg_mem[IDX_DSEL];
    end

    assign auto_powerdown = auto_pd;
    assign config_mode = cfg_open;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || por_rst);

    logic key_hit;
    assign key_hit = wr_index && host.wdata == KEY_ENTER;

    AST_KEY_FIRST: assert property (
        clk_en && key_hit && mode == FDCCFG_NORMAL
        |=> mode == FDCCFG_KEY1)
        else $error("first key did not arm configuration entry");

    AST_KEY_ENTRY: assert property (
        clk_en && key_hit && mode == FDCCFG_KEY1
        |=> mode == FDCCFG_CONFIG)
        else $error("two keys did not open configuration mode");

    AST_KEY_CANCEL: assert property (
        clk_en && wr_any && !key_hit && mode == FDCCFG_KEY1
        |=> mode == FDCCFG_NORMAL)
        else $error("foreign write did not cancel key entry");

    AST_EXIT: assert property (
        clk_en && cfg_open && wr_index && host.wdata == KEY_EXIT
        |=> !config_mode ##1 $stable(cfg_index))
        else $error("exit key did not leave configuration mode");

    AST_INDEX_GATED: assert property (
        !cfg_open && mode != FDCCFG_CONFIG |=> $stable(cfg_index))
        else $error("index moved outside configuration mode");

    AST_LOCKED: assert property (
        clk_en && !lock_open && wr_data
        |=> $stable(cfg_mem[cfg_index]) && !lock_open)
        else $error("locked register changed");

    AST_LOCKED_READ: assert property (
        clk_en && !lock_open && rd_data |=> !host_rdata_valid)
        else $error("locked register was readable");

    AST_PD_FLOAT: assert property (
        clk_en && auto_pd |=> !drv.motor_on_oe && !drv.drive_select_oe
        && !drv.write_serial_oe && !drv.write_gate_oe)
        else $error("drive pins driven in powerdown");

    AST_PD_ACTIVE: assert property (
        clk_en |=> drv.step_out == $past(core.step)
        && drv.rate_code_out == $past(core.rate_code))
        else $error("local control pins not passed through");

    AST_PD_HOST: assert property (
        clk_en && auto_pd |=> !drv.irq_out && !drv.dma_request_out)
        else $error("request pins raised in powerdown");

    AST_PD_STAY: assert property (
        clk_en && auto_pd && !wake && cfg_mem[IDX_APM][APM_BIT]
        && wr_dor |=> auto_pd)
        else $error("plain register write woke the device");

    AST_PD_WAKE: assert property (
        clk_en && auto_pd && wr_dor
        && host.wdata[7:DOR_MOTOR_LSB] != 4'h0 |=> !auto_pd)
        else $error("motor enable write did not wake");

    AST_POWER: assert property (
        clk_en && !cfg_mem[IDX_POWER][PWR_BIT] |=> !core_powered)
        else $error("core stayed powered with power bit clear");

    AST_INDEX_RANGE: assert property (
        clk_en && wr_index && host.wdata[7:5] != IDX_HIGH_ZERO
        |=> $stable(cfg_index))
        else $error("out of range index was taken");

    AST_DATA_REFUSED: assert property (
        clk_en && !cfg_open && rd_data |=> !host_rdata_valid)
        else $error("data port answered outside configuration mode");

    // a frozen edge must not move any state, resets aside
    AST_FREEZE: assert property (
        !clk_en |=> $stable(mode) && $stable(cfg_index) && $stable(auto_pd))
        else $error("state moved while the clock enable was low");

    COV_ENTER: cover property (mode == FDCCFG_KEY1 ##1 config_mode);
    COV_LOCK: cover property (lock_open ##1 !lock_open);
    COV_WAKE: cover property (auto_pd ##1 !auto_pd);
    COV_CANCEL: cover property (mode == FDCCFG_KEY1 ##1 mode == FDCCFG_NORMAL);
    COV_EXIT: cover property (config_mode ##1 !config_mode);

endmodule
